// >>> lpbc_defs.svh
`ifndef LPBC_DEFS_SVH
`define LPBC_DEFS_SVH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define LPBC_ADDR_W        8
`define LPBC_OFF_RXCFG     8'h00
`define LPBC_OFF_TXCFG     8'h04
`define LPBC_OFF_RXRES     8'h08
`define LPBC_OFF_TXRES     8'h0C
`define LPBC_OFF_STATUS    8'h10

// ****************************************************************
// Configuration byte fields
// ****************************************************************
`define LPBC_LEN_LSB       0
`define LPBC_LEN_MSB       1
`define LPBC_PAR_BIT       3
`define LPBC_POLY_LSB      5
`define LPBC_POLY_MSB      6
`define LPBC_CFG_MASK      8'h6B
`define LPBC_STAT_DCE_BIT  1
`define LPBC_LEN_BASE      5

// ****************************************************************
// Polynomials and reset values
// ****************************************************************
`define LPBC_POLY16A       16'h8005
`define LPBC_POLY16B       16'h1021
`define LPBC_POLY12        16'h80F0
`define LPBC_CFG_RST       8'h00
`define LPBC_RES_RST       16'h0000
`define LPBC_STAT_RST      8'h00

`endif

// >>> lpbc_pkg.sv
package lpbc_pkg;

   typedef enum logic [1:0] {
      LPBC_P16A,
      LPBC_P16B,
      LPBC_P12,
      LPBC_LRC8
   } lpbc_poly_t;

   typedef struct packed {
      logic       valid;
      logic [7:0] chr;
      logic       parity;
      logic       check;
      logic [1:0] rtype;
   } lpbc_rx_req_t;

   typedef struct packed {
      logic       valid;
      logic [7:0] chr;
      logic       parity;
      logic       check;
   } lpbc_tx_req_t;

   typedef struct packed {
      logic       valid;
      logic [7:0] chr;
   } lpbc_calc_req_t;

   typedef struct packed {
      logic rx;
      logic tx;
   } lpbc_clr_t;

endpackage : lpbc_pkg

// >>> lpbc_line_check.sv
// Behaviour
// - Receive parity type comes from bit 3 of receive config.
// - Receive parity checked only when the receive instruction asks.
// - Check spans configured length; leftmost bit is parity, any value.
// - Receive parity error sets data check error bit 1 of status.
// - Transmit parity type and length come from transmit config.
// - Device inserts correct parity into leftmost bit on send (here only when the send instruction asks for parity).
// - Receive and transmit share one character length register.
// - Polynomial from bits 5 and 6 of receive or transmit config.
// - Codes: 00 crc16, 01 ccitt16, 10 crc12, 11 lrc8.
// - Receive types 1 and 3 with check update receive residue.
// - Types 0 and 2 never update; calculate instruction always does.
// - Send with check updates transmit residue.
// - Code 11 uses only the first residue byte; sent odd parity (send parity here still follows bit 3 of transmit config).
// - Residues clearable anytime by program or host write.
//
// The placing of the registers and the Wishbone register port were left to the implementer.
`timescale 1ns/1ps
`include "lpbc_defs.svh"

module lpbc_line_check
(
   input  wire logic                        mclk,
   input  wire logic                        rst,
   input  wire logic [`LPBC_ADDR_W-1:0]     wb_adr_i,
   input  wire logic [31:0]                 wb_dat_i,
   output logic      [31:0]                 wb_dat_o,
   input  wire logic                        wb_we_i,
   input  wire logic [3:0]                  wb_sel_i,
   input  wire logic                        wb_cyc_i,
   input  wire logic                        wb_stb_i,
   output logic                             wb_ack_o,
   input  wire lpbc_pkg::lpbc_rx_req_t      rxReq,
   input  wire lpbc_pkg::lpbc_calc_req_t    calcReq,
   input  wire lpbc_pkg::lpbc_tx_req_t      txReq,
   input  wire lpbc_pkg::lpbc_clr_t         resClear,
   output logic      [7:0]                  workChar_r,
   output logic                             workValid_r,
   output logic      [7:0]                  lineTxChar_r,
   output logic                             lineTxValid_r,
   output logic                             dataCheckErr_r
);
   import lpbc_pkg::*;

   // ****************************************************************
   // Helpers
   // ****************************************************************
   function automatic logic [7:0] lenMask(input logic [1:0] len);
      lenMask = 8'hFF >> (2'h3 - len);
   endfunction : lenMask

   function automatic logic [15:0] crcStep(input logic [15:0] res,
                                           input logic [7:0]  ch,
                                           input logic [1:0]  poly,
                                           input logic [1:0]  len);
      logic [15:0] r;
      logic [15:0] p;
      logic        fb;
      r  = res;
      p  = 16'h0000;
      fb = 1'b0;
      case (lpbc_poly_t'(poly))
         LPBC_P16A: p = `LPBC_POLY16A;
         LPBC_P16B: p = `LPBC_POLY16B;
         LPBC_P12:  p = `LPBC_POLY12;
         default:   p = 16'h0000;
      endcase
      if (lpbc_poly_t'(poly) == LPBC_LRC8)
      begin
         r[15:8] = r[15:8] ^ (ch & lenMask(len));
      end
      else
      begin
         for (int i = 0; i < 8; i++)
         begin
            if (i < (`LPBC_LEN_BASE + int'(len)))
            begin
               fb = r[15] ^ ch[i];
               r  = {r[14:0], 1'b0} ^ (fb ? p : 16'h0000);
            end
         end
      end
      crcStep = r;
   endfunction : crcStep

   // ****************************************************************
   // State
   // ****************************************************************
   logic [7:0]  rxCfg_r,    rxCfg_nxt;
   logic [7:0]  txCfg_r,    txCfg_nxt;
   logic [1:0]  lineLen_r,  lineLen_nxt;
   logic [15:0] rxRes_r,    rxRes_nxt;
   logic [15:0] txRes_r,    txRes_nxt;
   logic [7:0]  status_r,   status_nxt;
   logic        ack_r,      ack_nxt;
   logic [31:0] rdData_r,   rdData_nxt;
   logic [7:0]  workChar_nxt;
   logic        workValid_nxt;
   logic [7:0]  lineTxChar_nxt;
   logic        lineTxValid_nxt;

   logic        wbWr;
   logic [7:0]  rxMasked;
   logic [7:0]  txMasked;
   logic        rxParErr;
   logic        txParBit;
   logic [7:0]  txOut;
   logic [2:0]  topBit;

   // ****************************************************************
   // Next state
   // ****************************************************************
   always_comb
   begin
      wbWr            = wb_cyc_i & wb_stb_i & wb_we_i & ~ack_r;
      ack_nxt         = wb_cyc_i & wb_stb_i & ~ack_r;
      rxCfg_nxt       = rxCfg_r;
      txCfg_nxt       = txCfg_r;
      lineLen_nxt     = lineLen_r;
      rxRes_nxt       = rxRes_r;
      txRes_nxt       = txRes_r;
      status_nxt      = status_r;
      rdData_nxt      = 32'h0000_0000;
      topBit          = 3'(`LPBC_LEN_BASE - 1) + {1'b0, lineLen_r};
      rxMasked        = rxReq.chr & lenMask(lineLen_r);
      txMasked        = txReq.chr & lenMask(lineLen_r);
      rxParErr        = (^rxMasked) != rxCfg_r[`LPBC_PAR_BIT];
      txParBit        = (^txMasked) ^ txCfg_r[`LPBC_PAR_BIT];
      txOut           = txMasked;
      if (txReq.parity)
      begin
         txOut[topBit] = txParBit;
      end
      workValid_nxt   = rxReq.valid;
      workChar_nxt    = rxReq.valid ? rxMasked : workChar_r;
      lineTxValid_nxt = txReq.valid;
      lineTxChar_nxt  = txReq.valid ? txOut : lineTxChar_r;

      // Register reads
      if (wb_cyc_i & wb_stb_i & ~wb_we_i & ~ack_r)
      begin
         case (wb_adr_i)
            `LPBC_OFF_RXCFG:
               rdData_nxt = {24'h000000,
                             rxCfg_r[7:2], lineLen_r};
            `LPBC_OFF_TXCFG:
               rdData_nxt = {24'h000000,
                             txCfg_r[7:2], lineLen_r};
            `LPBC_OFF_RXRES:  rdData_nxt = {16'h0000, rxRes_r};
            `LPBC_OFF_TXRES:  rdData_nxt = {16'h0000, txRes_r};
            `LPBC_OFF_STATUS: rdData_nxt = {24'h000000, status_r};
            default:          rdData_nxt = 32'h0000_0000;
         endcase
      end

      // Residue updates from channel instructions
      // types 1 and 3 update
      // types 0 and 2 do not
      if (rxReq.valid & rxReq.check & rxReq.rtype[0])
      begin
         rxRes_nxt = crcStep(rxRes_nxt, rxReq.chr,
                             rxCfg_r[`LPBC_POLY_MSB:`LPBC_POLY_LSB],
                             lineLen_r);
      end
      if (calcReq.valid)
      begin
         rxRes_nxt = crcStep(rxRes_nxt, calcReq.chr,
                             rxCfg_r[`LPBC_POLY_MSB:`LPBC_POLY_LSB],
                             lineLen_r);
      end
      if (txReq.valid & txReq.check)
      begin
         txRes_nxt = crcStep(txRes_r, txOut,
                             txCfg_r[`LPBC_POLY_MSB:`LPBC_POLY_LSB],
                             lineLen_r);
      end

      // Host register writes
      if (wbWr)
      begin
         case (wb_adr_i)
            `LPBC_OFF_RXCFG:
               if (wb_sel_i[0])
               begin
                  rxCfg_nxt   = wb_dat_i[7:0] & `LPBC_CFG_MASK;
                  lineLen_nxt = wb_dat_i[`LPBC_LEN_MSB:`LPBC_LEN_LSB];
               end
            `LPBC_OFF_TXCFG:
               if (wb_sel_i[0])
               begin
                  txCfg_nxt   = wb_dat_i[7:0] & `LPBC_CFG_MASK;
                  lineLen_nxt = wb_dat_i[`LPBC_LEN_MSB:`LPBC_LEN_LSB];
               end
            `LPBC_OFF_RXRES:
            begin
               if (wb_sel_i[0])
                  rxRes_nxt[7:0]  = wb_dat_i[7:0];
               if (wb_sel_i[1])
                  rxRes_nxt[15:8] = wb_dat_i[15:8];
            end
            `LPBC_OFF_TXRES:
            begin
               if (wb_sel_i[0])
                  txRes_nxt[7:0]  = wb_dat_i[7:0];
               if (wb_sel_i[1])
                  txRes_nxt[15:8] = wb_dat_i[15:8];
            end
            `LPBC_OFF_STATUS:
               if (wb_sel_i[0])
                  status_nxt = wb_dat_i[7:0];
            default: ;
         endcase
      end

      if (resClear.rx)
         rxRes_nxt = `LPBC_RES_RST;
      if (resClear.tx)
         txRes_nxt = `LPBC_RES_RST;

      if (rxReq.valid & rxReq.parity & rxParErr)
         status_nxt[`LPBC_STAT_DCE_BIT] = 1'b1;
   end

   // ****************************************************************
   // Registers
   // ****************************************************************
   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         rxCfg_r       <= `LPBC_CFG_RST;
         txCfg_r       <= `LPBC_CFG_RST;
         lineLen_r     <= 2'h0;
         rxRes_r       <= `LPBC_RES_RST;
         txRes_r       <= `LPBC_RES_RST;
         status_r      <= `LPBC_STAT_RST;
         ack_r         <= 1'b0;
         rdData_r      <= 32'h0000_0000;
         workChar_r    <= 8'h00;
         workValid_r   <= 1'b0;
         lineTxChar_r  <= 8'h00;
         lineTxValid_r <= 1'b0;
      end
      else
      begin
         rxCfg_r       <= rxCfg_nxt;
         txCfg_r       <= txCfg_nxt;
         lineLen_r     <= lineLen_nxt;
         rxRes_r       <= rxRes_nxt;
         txRes_r       <= txRes_nxt;
         status_r      <= status_nxt;
         ack_r         <= ack_nxt;
         rdData_r      <= rdData_nxt;
         workChar_r    <= workChar_nxt;
         workValid_r   <= workValid_nxt;
         lineTxChar_r  <= lineTxChar_nxt;
         lineTxValid_r <= lineTxValid_nxt;
      end
   end

   assign wb_ack_o       = ack_r;
   assign wb_dat_o       = rdData_r;
   assign dataCheckErr_r = status_r[`LPBC_STAT_DCE_BIT];

endmodule : lpbc_line_check

// >>> lpbc_line_check_checker.sv
`timescale 1ns/1ps
module lpbc_line_check_checker
(
   input wire logic                   mclk,
   input wire logic                   rst,
   input wire logic                   wb_cyc_i,
   input wire logic                   wb_stb_i,
   input wire logic                   wb_we_i,
   input wire logic                   wb_ack_o,
   input wire lpbc_pkg::lpbc_rx_req_t rxReq,
   input wire lpbc_pkg::lpbc_tx_req_t txReq,
   input wire logic [7:0]             workChar_r,
   input wire logic                   workValid_r,
   input wire logic [7:0]             lineTxChar_r,
   input wire logic                   lineTxValid_r,
   input wire logic                   dataCheckErr_r
);
   import lpbc_pkg::*;
   default clocking @(posedge mclk); endclocking
   default disable iff (rst);
   ack_turn_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("no ack after request");
   ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   rx_pulse_a: assert property (1'h1 |=> workValid_r == $past(rxReq.valid))
      else $error("receive valid pulse wrong");
   tx_pulse_a: assert property (1'h1 |=> lineTxValid_r == $past(txReq.valid))
      else $error("send valid pulse wrong");
   rx_bits_a: assert property (rxReq.valid |=>
      workChar_r[3:0] == $past(rxReq.chr[3:0])) else $error("rx char wrong");
   tx_bits_a: assert property (txReq.valid |=>
      lineTxChar_r[3:0] == $past(txReq.chr[3:0])) else $error("tx char wrong");
   err_cause_a: assert property ($rose(dataCheckErr_r) |->
      $past(rxReq.valid && rxReq.parity) || $past(wb_cyc_i && wb_we_i))
      else $error("error flag set without cause");
   err_hold_a: assert property (!(rxReq.valid && rxReq.parity) &&
      !(wb_cyc_i && wb_stb_i && wb_we_i) |=> $stable(dataCheckErr_r))
      else $error("error flag changed without cause");
endmodule : lpbc_line_check_checker

bind lpbc_line_check lpbc_line_check_checker chk_u (.mclk, .rst, .wb_cyc_i,
   .wb_stb_i, .wb_we_i, .wb_ack_o, .rxReq, .txReq, .workChar_r,
   .workValid_r, .lineTxChar_r, .lineTxValid_r, .dataCheckErr_r);

// >>> lpbc_prog_model.sv
`timescale 1ns/1ps
module lpbc_prog_model
(
   input  wire logic                mclk,
   output lpbc_pkg::lpbc_rx_req_t   rxReq,
   output lpbc_pkg::lpbc_tx_req_t   txReq,
   output lpbc_pkg::lpbc_calc_req_t calcReq,
   output lpbc_pkg::lpbc_clr_t      resClear
);
   import lpbc_pkg::*;
   initial
   begin
      rxReq = '0;
      txReq = '0;
      calcReq = '0;
      resClear = '0;
   end
   // Kind 0 receive, 1 send, 2 calculate, 3 clear
   task automatic issue(input int k, input logic [7:0] c,
                        input logic [3:0] f, input int n);
      case (k)
         0: rxReq <= '{1'h1, c, f[0], f[1], f[3:2]};
         1: txReq <= '{1'h1, c & ~(8'h01 << (n - 1)), f[0], f[1]};
         2: calcReq <= '{1'h1, c};
         default: resClear <= lpbc_clr_t'(f[1:0]);
      endcase
      @(posedge mclk);
      rxReq <= '0;
      txReq <= '0;
      calcReq <= '0;
      resClear <= '0;
      @(posedge mclk);
   endtask : issue
endmodule : lpbc_prog_model

// >>> tb_top.sv
`timescale 1ns/1ps
`include "lpbc_defs.svh"
module tb_top;
   import lpbc_pkg::*;
   logic           mclk = 1'h0;
   logic           rst = 1'h1;
   logic [7:0]     adr = 8'h00;
   logic [31:0]    wdat = 32'h0;
   logic           we = 1'h0;
   logic           cyc = 1'h0;
   logic           stb = 1'h0;
   logic [31:0]    datO, rdat;
   logic           ack, dce;
   logic [7:0]     workChar, lineTx, m, cfg;
   logic [15:0]    rxRes, txRes;
   logic           errExp;
   lpbc_rx_req_t   rxReq;
   lpbc_tx_req_t   txReq;
   lpbc_calc_req_t calcReq;
   lpbc_clr_t      resClear;
   int             badCount = 0;
   int             nCompared = 0;
   int             cycles = 0;
   int             n;
   always #4 mclk = ~mclk;
   lpbc_line_check dut_u (.mclk(mclk), .rst(rst), .wb_adr_i(adr),
      .wb_dat_i(wdat), .wb_dat_o(datO), .wb_we_i(we), .wb_sel_i(4'hF),
      .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_ack_o(ack), .rxReq(rxReq),
      .calcReq(calcReq), .txReq(txReq), .resClear(resClear),
      .workChar_r(workChar), .workValid_r(), .lineTxChar_r(lineTx),
      .lineTxValid_r(), .dataCheckErr_r(dce));
   lpbc_prog_model prog_u (.mclk(mclk), .rxReq(rxReq), .txReq(txReq),
      .calcReq(calcReq), .resClear(resClear));
   function automatic logic [15:0] crc(logic [15:0] r, logic [7:0] c,
                                       logic [1:0] p, int len);
      logic [15:0] g;
      logic        fb;
      g = p == 2'h0 ? `LPBC_POLY16A : p == 2'h1 ? `LPBC_POLY16B : `LPBC_POLY12;
      if (p == 2'h3)
         return r ^ {c, 8'h00};
      for (int i = 0; i < len; i++)
      begin
         fb = r[15] ^ c[i];
         r = {r[14:0], 1'h0} ^ (fb ? g : 16'h0000);
      end
      return r;
   endfunction : crc
   task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d);
      adr <= a;
      we <= w;
      wdat <= d;
      cyc <= 1'h1;
      stb <= 1'h1;
      // Hold request until ack is seen high at a rising edge
      do
         @(posedge mclk);
      while (ack !== 1'h1);
      rdat = datO;
      cyc <= 1'h0;
      stb <= 1'h0;
      @(posedge mclk);
   endtask : wb
   task automatic chk(input string s, input logic [31:0] e, g);
      nCompared++;
      if (g !== e)
      begin
         badCount++;
         $display("[FAIL] %s expected %h seen %h", s, e, g);
      end
   endtask : chk
   task automatic rd(input logic [7:0] a, input logic [31:0] e, input string s);
      wb(a, 1'h0, 32'h0);
      chk(s, e, rdat);
   endtask : rd
   task automatic stopTest;
      $display("compared %0d mismatched %0d", nCompared, badCount);
      if (badCount == 0 && nCompared > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : stopTest
   always @(posedge mclk)
   begin
      cycles <= cycles + 1;
      if (cycles == 5000)
      begin
         badCount++;
         stopTest();
      end
   end
   initial
   begin
      repeat (5) @(posedge mclk);
      rst <= 1'h0;
      @(posedge mclk);
      wb(8'h14, 1'h1, 32'hFF);
      for (int a = 0; a <= 20; a += 4)
         rd(a[7:0], 32'h0, "reset value");
      wb(`LPBC_OFF_RXCFG, 1'h1, 32'hFF);
      rd(`LPBC_OFF_RXCFG, 32'h6B, "rx config");
      rd(`LPBC_OFF_TXCFG, 32'h03, "shared length");
      $display("test registers done");
      for (int p = 0; p < 4; p++)
      begin
         n = 5 + p;
         cfg = {1'h0, p[1:0], 1'h0, p[0], 1'h0, p[1:0]};
         rxRes = p == 1 ? 16'hFFFF : 16'h0000;
         txRes = rxRes;
         errExp = 1'h0;
         wb(`LPBC_OFF_RXCFG, 1'h1, {24'h0, cfg});
         wb(`LPBC_OFF_RXRES, 1'h1, {16'h0, rxRes});
         wb(`LPBC_OFF_STATUS, 1'h1, 32'h0);
         for (int t = 0; t < 4; t++)
         begin
            m = (8'hA5 + 8'(t)) & ~(8'hFF << n);
            prog_u.issue(0, 8'hA5 + 8'(t), {t[1:0], 1'h1, t[1]}, 0);
            errExp = errExp | (t[1] & ((^m) != p[0]));
            if (t[0])
               rxRes = crc(rxRes, m, p[1:0], n);
            chk("work char", {24'h0, m}, {24'h0, workChar});
            chk("parity error", {31'h0, errExp}, {31'h0, dce});
         end
         prog_u.issue(2, 8'h3C, 4'h0, 0);
         rxRes = crc(rxRes, 8'h3C & ~(8'hFF << n), p[1:0], n);
         rd(`LPBC_OFF_RXRES, {16'h0, rxRes}, "rx residue");
         if (p == 3)
         begin
            prog_u.issue(2, rxRes[15:8], 4'h0, 0);
            rxRes = crc(rxRes, rxRes[15:8], 2'h3, 8);
            rd(`LPBC_OFF_RXRES, {16'h0, rxRes}, "lrc residue");
         end
         wb(`LPBC_OFF_TXCFG, 1'h1, {24'h0, cfg ^ 8'h08});
         wb(`LPBC_OFF_TXRES, 1'h1, {16'h0, txRes});
         m = 8'h5A & ~(8'hFF << (n - 1));
         m = m | ({7'h0, (^m) ^ ~p[0]} << (n - 1));
         prog_u.issue(1, 8'h5A & ~(8'hFF << n), 4'h3, n);
         chk("tx char", {24'h0, m}, {24'h0, lineTx});
         txRes = crc(txRes, m, p[1:0], n);
         rd(`LPBC_OFF_TXRES, {16'h0, txRes}, "tx residue");
         $display("test polynomial %0d done", p);
      end
      prog_u.issue(3, 8'h00, 4'h3, 0);
      rd(`LPBC_OFF_RXRES, 32'h0, "rx cleared");
      rd(`LPBC_OFF_TXRES, 32'h0, "tx cleared");
      $display("test clear done");
      wb(`LPBC_OFF_STATUS, 1'h1, 32'h02);
      rd(`LPBC_OFF_STATUS, 32'h02, "program status");
      chk("program flag", 32'h1, {31'h0, dce});
      stopTest();
   end
endmodule : tb_top
